// [rtl/period_match_timer.sv]
// top of the 8-bit period timer: registers, counter, flag and interrupt
// assumes a master that holds strobes one cycle and never waits
`timescale 1ns/10ps
module period_match_timer
(
   // clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       reset_n_i,
   // register port
   input  wire logic [2:0] addr_i,
   input  wire logic [7:0] wr_data_i,
   input  wire logic       wr_en_i,
   input  wire logic       rd_en_i,
   output logic      [7:0] rd_data_o,
   // events
   output logic            match_o,
   output logic            irq_o
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [1:0]                  inst_div;
   logic                        inst_ce;
   logic [7:0]                  count;
   logic [7:0]                  period;
   period_timer_pkg::control_t  control;
   logic [7:0]                  flags;
   logic [7:0]                  enables;
   logic                        wr_count;
   logic                        wr_period;
   logic                        wr_control;
   logic                        wr_flags;
   logic                        wr_enables;
   logic                        scaler_clear;
   logic                        pre_tick;
   logic                        period_match;
   logic                        post_done;
   logic [7:0]                  next_rd_data;

   // one address comparison, used by the write decode; the read port decodes with a case
   function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
      return a == off;
   endfunction

   // ------------------------------------------------------------------
   // instruction clock
   // ------------------------------------------------------------------

   // one enable every fourth system clock stands in for osc/4
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         inst_div <= 2'h0;
         inst_ce  <= 1'b0;
      end
      else
      begin
         inst_div <= inst_div + 2'h1;
         inst_ce  <= (inst_div == period_timer_pkg::INST_LAST);
      end
   end

   // ------------------------------------------------------------------
   // write decode
   // ------------------------------------------------------------------

   // strobes are one cycle, so each decode is a one-cycle pulse
   assign wr_count   = wr_en_i && hit(addr_i, period_timer_pkg::OFF_COUNT);
   assign wr_period  = wr_en_i && hit(addr_i, period_timer_pkg::OFF_PERIOD);
   assign wr_control = wr_en_i && hit(addr_i, period_timer_pkg::OFF_CONTROL);
   assign wr_flags   = wr_en_i && hit(addr_i, period_timer_pkg::OFF_FLAGS);
   assign wr_enables = wr_en_i && hit(addr_i, period_timer_pkg::OFF_ENABLES);

   // both scalers restart on a count or control write
   assign scaler_clear = wr_count || wr_control;

   // ------------------------------------------------------------------
   // scalers
   // ------------------------------------------------------------------

   // prescaler sits between the instruction enable and the counter
   timer_prescaler u_prescaler
   (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .inst_ce_i (inst_ce),
      .run_i     (control.timer_on),
      .clear_i   (scaler_clear),
      .select_i  (control.prescale_select),
      .tick_o    (pre_tick)
   );

   // a match is the tick that finds count equal to period
   assign period_match = pre_tick && !wr_count && (count == period);

   // postscaler counts matches
   timer_postscaler u_postscaler
   (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .match_i   (period_match),
      .clear_i   (scaler_clear),
      .select_i  (control.postscale_select),
      .done_o    (post_done)
   );

   // ------------------------------------------------------------------
   // counter and period
   // ------------------------------------------------------------------

   // a software write beats a tick landing in the same cycle; control writes never load it
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         count <= period_timer_pkg::COUNT_RESET;
      else if (wr_count)
         count <= wr_data_i;
      else if (period_match)
         count <= period_timer_pkg::COUNT_RESET;
      else if (pre_tick)
         count <= count + 8'h01;
   end

   // period register; a period below the count lets it run to FFh and wrap
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         period <= period_timer_pkg::PERIOD_RESET;
      else if (wr_period)
         period <= wr_data_i;
   end

   // control register; bit 7 is never stored
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         control <= period_timer_pkg::CONTROL_RESET;
      else if (wr_control)
      begin
         control       <= period_timer_pkg::control_t'(wr_data_i);
         control.spare <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // flag, enable and interrupt
   // ------------------------------------------------------------------

   // flag is cleared by writing zero; a set in the same cycle wins
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         flags <= period_timer_pkg::READ_ZERO;
      else if (post_done)
         flags[period_timer_pkg::MATCH_BIT] <= 1'b1;
      else if (wr_flags && !wr_data_i[period_timer_pkg::MATCH_BIT])
         flags[period_timer_pkg::MATCH_BIT] <= 1'b0;
   end

   // enable register has the flag layout; only the match bit is stored
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         enables <= period_timer_pkg::READ_ZERO;
      else if (wr_enables)
         enables[period_timer_pkg::MATCH_BIT] <= wr_data_i[period_timer_pkg::MATCH_BIT];
   end

   // level interrupt, one cycle behind the flag so it leaves a flop
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(flags & enables);
   end

   // match pulse for neighbours, registered for a clean output
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         match_o <= 1'b0;
      else
         match_o <= period_match;
   end

   // ------------------------------------------------------------------
   // read port
   // ------------------------------------------------------------------

   // reads have no side effect; unmapped offsets read zero
   always_comb
   begin
      next_rd_data = period_timer_pkg::READ_ZERO;
      unique case (addr_i)
         period_timer_pkg::OFF_COUNT:   next_rd_data = count;
         period_timer_pkg::OFF_PERIOD:  next_rd_data = period;
         period_timer_pkg::OFF_CONTROL: next_rd_data = {1'b0, control[6:0]};
         period_timer_pkg::OFF_FLAGS:   next_rd_data = flags;
         period_timer_pkg::OFF_ENABLES: next_rd_data = enables;
         default:                       next_rd_data = period_timer_pkg::READ_ZERO;
      endcase
   end

   // data stand only in the cycle after the strobe
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         rd_data_o <= period_timer_pkg::READ_ZERO;
      else if (rd_en_i)
         rd_data_o <= next_rd_data;
      else
         rd_data_o <= period_timer_pkg::READ_ZERO;
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------

   // three quiet cycles between instruction enables
   sequence seq_inst_gap;
      !inst_ce [*3] ##1 inst_ce;
   endsequence

   a_inst_rate: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      inst_ce |=> seq_inst_gap)
      else $error("instruction enable not every fourth cycle");

   a_prescale_unity: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      inst_ce && control.timer_on && control.prescale_select == 2'h0
      && !scaler_clear |-> pre_tick)
      else $error("prescale 1 missed a tick");

   a_prescale_four: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      pre_tick && control.prescale_select == 2'h1 |=> !pre_tick [*8])
      else $error("prescale 4 ticked too soon");

   a_count_step: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      pre_tick && !wr_count && count != period |=> count == 8'($past(count) + 8'h01))
      else $error("count did not step by one");

   a_count_wrap: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      period_match |=> count == period_timer_pkg::COUNT_RESET && match_o)
      else $error("count did not reload after match");

   a_post_cause: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      post_done |-> period_match && count == period)
      else $error("postscaler fired without a match");

   a_flag_set: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      post_done |=> flags[period_timer_pkg::MATCH_BIT])
      else $error("flag not set by postscaler");

   a_post_ratio: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      period_match && !scaler_clear && control.postscale_select == 4'h0 |-> post_done)
      else $error("ratio 1:1 missed a flag");

   a_count_write: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      wr_count |=> count == $past(wr_data_i))
      else $error("count write lost");

   a_stopped_hold: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !control.timer_on && !wr_count |=> $stable(count))
      else $error("count moved while stopped");

   a_ctl_keeps_count: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      wr_control && !wr_count |=> $stable(count))
      else $error("control write changed count");

   a_spare_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      rd_en_i && addr_i == period_timer_pkg::OFF_CONTROL |=> !rd_data_o[7])
      else $error("control bit 7 read as one");

   a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      flags[period_timer_pkg::MATCH_BIT] && !wr_flags
      |=> flags[period_timer_pkg::MATCH_BIT])
      else $error("flag dropped without a write");

   a_irq_level: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      |(flags & enables) |=> irq_o)
      else $error("interrupt not raised for enabled flag");

   // ------------------------------------------------------------------
   // register and event checks
   // ------------------------------------------------------------------

   // a tick that finds the count at the period value
   sequence seq_match_tick;
      pre_tick && !wr_count && count == period;
   endsequence

   // one cycle on: count back at zero with the pulse out
   sequence seq_reload_seen;
      count == period_timer_pkg::COUNT_RESET && match_o;
   endsequence

   a_match_chain: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      seq_match_tick |=> seq_reload_seen ##1 !match_o)
      else $error("match pulse or reload out of step");

   a_tick_gated: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      pre_tick |-> control.timer_on && inst_ce)
      else $error("tick while stopped or off the instruction enable");

   a_clear_no_tick: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      scaler_clear |-> !pre_tick && !post_done)
      else $error("tick in a cycle that clears the scalers");

   a_period_write: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      wr_period |=> period == $past(wr_data_i))
      else $error("period write lost");

   a_period_hold: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !wr_period |=> $stable(period))
      else $error("period changed without a write");

   a_ctl_write: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      wr_control |=> control[6:0] == $past(wr_data_i[6:0]))
      else $error("control fields not stored");

   a_spare_store: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !control.spare)
      else $error("control bit 7 holds a one");

   a_rd_count: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      rd_en_i && addr_i == period_timer_pkg::OFF_COUNT |=> rd_data_o == $past(count))
      else $error("count read returned a wrong byte");

   a_rd_period: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      rd_en_i && addr_i == period_timer_pkg::OFF_PERIOD |=> rd_data_o == $past(period))
      else $error("period read returned a wrong byte");

   a_rd_idle: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !rd_en_i |=> rd_data_o == period_timer_pkg::READ_ZERO)
      else $error("read data left standing");

   a_flag_clear: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      wr_flags && !wr_data_i[period_timer_pkg::MATCH_BIT] && !post_done
      |=> !flags[period_timer_pkg::MATCH_BIT])
      else $error("flag not cleared by a zero write");

   a_enable_write: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      wr_enables |=> enables[period_timer_pkg::MATCH_BIT]
      == $past(wr_data_i[period_timer_pkg::MATCH_BIT]))
      else $error("interrupt enable write lost");

   a_irq_masked: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !(|(flags & enables)) |=> !irq_o)
      else $error("interrupt raised with no enabled flag");

endmodule // period_match_timer

// [rtl/period_timer_pkg.sv]
// constants, field layouts and shared decoders of the 8-bit period timer
// assumes one 25 MHz clock and a plain address/strobe register port
package period_timer_pkg;

   // -----------------------------------------------------------------
   // clocking
   // -----------------------------------------------------------------
   localparam int unsigned CLK_HZ   = 25_000_000;
   localparam int unsigned INST_DIV = 4;
   localparam logic [1:0]  INST_LAST = 2'(INST_DIV - 1);

   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam int unsigned ADDR_W      = 3;
   localparam logic [2:0]  OFF_COUNT   = 3'h0;
   localparam logic [2:0]  OFF_PERIOD  = 3'h1;
   localparam logic [2:0]  OFF_CONTROL = 3'h2;
   localparam logic [2:0]  OFF_FLAGS   = 3'h3;
   localparam logic [2:0]  OFF_ENABLES = 3'h4;
   localparam logic [7:0]  COUNT_RESET  = 8'h00;
   localparam logic [7:0]  PERIOD_RESET = 8'hFF;
   localparam logic [7:0]  READ_ZERO    = 8'h00;
   localparam int unsigned MATCH_BIT    = 1;

   // -----------------------------------------------------------------
   // scaler terminal counts
   // -----------------------------------------------------------------
   localparam logic [3:0] PRE_LAST_1  = 4'h0;
   localparam logic [3:0] PRE_LAST_4  = 4'h3;
   localparam logic [3:0] PRE_LAST_16 = 4'hF;
   localparam logic [3:0] SCALE_ZERO  = 4'h0;

   // control register layout, bit 7 first
   typedef struct packed {
      logic       spare;
      logic [3:0] postscale_select;
      logic       timer_on;
      logic [1:0] prescale_select;
   } control_t;

   localparam control_t CONTROL_RESET = '0;

   // terminal prescaler count for a select code
   function automatic logic [3:0] prescale_last(input logic [1:0] sel);
      if (sel[1])
         return PRE_LAST_16;
      else if (sel[0])
         return PRE_LAST_4;
      else
         return PRE_LAST_1;
   endfunction

endpackage

// [rtl/timer_prescaler.sv]
// prescaler between the instruction-clock enable and the period counter
// assumes inst_ce_i is a one-cycle pulse on the same clock
`timescale 1ns/10ps
module timer_prescaler
(
   // clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       reset_n_i,
   // control
   input  wire logic       inst_ce_i,
   input  wire logic       run_i,
   input  wire logic       clear_i,
   input  wire logic [1:0] select_i,
   // tick to the counter
   output logic            tick_o
);

   logic [3:0] cnt;

   // a clear wins over a tick so a count or control write never also advances
   assign tick_o = run_i && inst_ce_i && !clear_i
                   && (cnt == period_timer_pkg::prescale_last(select_i));

   // prescale counter, frozen while stopped
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         cnt <= period_timer_pkg::SCALE_ZERO;
      else if (clear_i)
         cnt <= period_timer_pkg::SCALE_ZERO;
      else if (tick_o)
         cnt <= period_timer_pkg::SCALE_ZERO;
      else if (run_i && inst_ce_i)
         cnt <= cnt + 4'h1;
   end

   a_pre_clear: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      clear_i |=> cnt == period_timer_pkg::SCALE_ZERO)
      else $error("prescaler not cleared");

endmodule // timer_prescaler

// [rtl/timer_postscaler.sv]
// postscaler counting period matches, pulses when the ratio is reached
// assumes match_i is a one-cycle pulse on the same clock
`timescale 1ns/10ps
module timer_postscaler
(
   // clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       reset_n_i,
   // control
   input  wire logic       match_i,
   input  wire logic       clear_i,
   input  wire logic [3:0] select_i,
   // ratio reached
   output logic            done_o
);

   logic [3:0] cnt;

   // code n ends a run of n+1 matches
   assign done_o = match_i && !clear_i && (cnt == select_i);

   // match counter
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         cnt <= period_timer_pkg::SCALE_ZERO;
      else if (clear_i)
         cnt <= period_timer_pkg::SCALE_ZERO;
      else if (done_o)
         cnt <= period_timer_pkg::SCALE_ZERO;
      else if (match_i)
         cnt <= cnt + 4'h1;
   end

   a_post_clear: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      clear_i |=> cnt == period_timer_pkg::SCALE_ZERO)
      else $error("postscaler not cleared");

endmodule // timer_postscaler

// [tb/tb.sv]
// self-checking bench of the 8-bit period timer, random stimulus from a fixed seed
// assumes the design package and top module are compiled first, one 25 MHz clock
`timescale 1ns/10ps
module tb;

   // -----------------------------------------------------------------
   // signals and counters
   // -----------------------------------------------------------------
   logic       ref_clk_i;
   logic       reset_n_i;
   logic [2:0] addr_i;
   logic [7:0] wr_data_i;
   logic       wr_en_i;
   logic       rd_en_i;
   logic [7:0] rd_data_o;
   logic       match_o;
   logic       irq_o;
   int         err_count;
   int         checks_done;
   int         seed;
   int         n;
   logic [7:0] d;
   logic [7:0] x;
   logic [7:0] p;

   period_match_timer dut
   (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .addr_i    (addr_i),
      .wr_data_i (wr_data_i),
      .wr_en_i   (wr_en_i),
      .rd_en_i   (rd_en_i),
      .rd_data_o (rd_data_o),
      .match_o   (match_o),
      .irq_o     (irq_o)
   );

   // 40 ns clock
   initial
   begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   // -----------------------------------------------------------------
   // bus tasks and expectation helpers
   // -----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one write cycle; strobe dropped at the edge that takes it
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      wr_en_i   <= 1'b1;
      addr_i    <= a;
      wr_data_i <= v;
      @(posedge ref_clk_i);
      wr_en_i   <= 1'b0;
   endtask

   // read data only stand in the cycle after the strobe, so sample there
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge ref_clk_i);
      rd_en_i <= 1'b1;
      addr_i  <= a;
      @(posedge ref_clk_i);
      rd_en_i <= 1'b0;
      #1 v = rd_data_o;
   endtask

   task automatic cycles(input int c);
      repeat (c) @(posedge ref_clk_i);
      #1;
   endtask

   // cycles until the next match pulse, bounded so a dead timer cannot hang
   task automatic wait_match(output int c);
      c = 0;
      do
      begin
         @(posedge ref_clk_i);
         #1 c++;
      end
      while (match_o !== 1'b1 && c < 3000);
   endtask

   task automatic do_reset();
      @(posedge ref_clk_i);
      reset_n_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
   endtask

   task automatic done(input string name);
      $display("test %s finished, mismatches so far %0d", name, err_count);
   endtask

   function automatic int pre_div(input logic [1:0] code);
      return code[1] ? 16 : (code[0] ? 4 : 1);
   endfunction

   // one match every period+1 ticks, one tick per div instruction cycles
   function automatic int match_gap(input logic [1:0] code, input logic [7:0] per);
      return 4 * pre_div(code) * (int'(per) + 1);
   endfunction

   function automatic logic [7:0] ctl(input logic [3:0] post, input logic on,
                                      input logic [1:0] pre);
      return {1'b0, post, on, pre};
   endfunction

   task automatic results();
      $display("comparisons %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // watchdog well beyond the few thousand cycles the tests take
   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      err_count++;
      results();
   end

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial
   begin
      err_count   = 0;
      checks_done = 0;
      seed        = 89000;
      reset_n_i   = 1'b0;
      addr_i      = 3'h0;
      wr_data_i   = 8'h00;
      wr_en_i     = 1'b0;
      rd_en_i     = 1'b0;
      repeat (3) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;

      // reset values and unmapped offsets
      rd(period_timer_pkg::OFF_COUNT, d);   check(d, 8'h00);
      rd(period_timer_pkg::OFF_PERIOD, d);  check(d, 8'hFF);
      rd(period_timer_pkg::OFF_CONTROL, d); check(d, 8'h00);
      for (int a = 5; a < 8; a++)
      begin
         wr(3'(a), 8'hA5);
         rd(3'(a), d);
         check(d, 8'h00);
      end
      done("reset");

      // full-byte access while stopped; bit 7 of control has no storage
      for (int i = 0; i < 4; i++)
      begin
         x = 8'($random(seed));
         p = 8'($random(seed));
         d = 8'($random(seed)) & 8'hFB;
         wr(period_timer_pkg::OFF_COUNT, x);
         wr(period_timer_pkg::OFF_PERIOD, p);
         wr(period_timer_pkg::OFF_CONTROL, d | 8'h80);
         cycles(20);
         rd(period_timer_pkg::OFF_COUNT, d); check(d, x);
         rd(period_timer_pkg::OFF_PERIOD, d); check(d, p);
         rd(period_timer_pkg::OFF_CONTROL, d); check(d[7], 1'b0);
      end
      done("access");

      // count and control writes restart the prescaler from a partial state
      wr(period_timer_pkg::OFF_PERIOD, 8'hFF);
      for (int i = 0; i < 2; i++)
      begin
         wr(period_timer_pkg::OFF_CONTROL, ctl(4'h0, 1'b1, 2'b10));
         cycles(5 + ($random(seed) & 8'h37));
         x = 8'($random(seed)) & 8'h7F;
         wr(period_timer_pkg::OFF_COUNT, x);
         // stay well short of the first tick so the byte read is the byte kept
         cycles(5 + ($random(seed) & 8'h1F));
         rd(period_timer_pkg::OFF_COUNT, x);
         if (i == 1)
            wr(period_timer_pkg::OFF_CONTROL, ctl(4'h0, 1'b1, 2'b11));
         else
            wr(period_timer_pkg::OFF_COUNT, x);
         cycles(47);
         rd(period_timer_pkg::OFF_COUNT, d); check(d, x);
         cycles(22);
         rd(period_timer_pkg::OFF_COUNT, d); check(d, x + 8'h01);
      end
      done("scaler clear");

      // match spacing for every prescale code and small random periods
      for (int code = 0; code < 4; code++)
      begin
         p = 8'($random(seed)) & 8'h03;
         wr(period_timer_pkg::OFF_CONTROL, 8'h00);
         wr(period_timer_pkg::OFF_PERIOD, p);
         wr(period_timer_pkg::OFF_COUNT, 8'h00);
         wr(period_timer_pkg::OFF_CONTROL, ctl(4'h0, 1'b1, 2'(code)));
         wait_match(n);
         wait_match(n);
         check(16'(n), 16'(match_gap(2'(code), p)));
      end
      done("prescale");

      // every postscale code: irq after exactly n+1 matches
      wr(period_timer_pkg::OFF_PERIOD, 8'h00);
      wr(period_timer_pkg::OFF_ENABLES, 8'h02);
      for (int code = 0; code < 16; code++)
      begin
         wr(period_timer_pkg::OFF_CONTROL, 8'h00);
         wr(period_timer_pkg::OFF_FLAGS, 8'h00);
         wr(period_timer_pkg::OFF_COUNT, 8'h00);
         wr(period_timer_pkg::OFF_CONTROL, ctl(4'(code), 1'b1, 2'b00));
         n = 0;
         for (int c = 0; c < 200 && irq_o !== 1'b1; c++)
         begin
            @(posedge ref_clk_i);
            #1;
            if (match_o === 1'b1)
               n++;
         end
         check(16'(n), 16'(code + 1));
      end
      done("postscale");

      // flag sticks, writing one leaves it, mask gates irq, writing zero clears
      wr(period_timer_pkg::OFF_CONTROL, 8'h00);
      wr(period_timer_pkg::OFF_FLAGS, 8'hFF);
      rd(period_timer_pkg::OFF_FLAGS, d); check(d & 8'h02, 8'h02);
      wr(period_timer_pkg::OFF_ENABLES, 8'h00);
      cycles(2); check(irq_o, 1'b0);
      wr(period_timer_pkg::OFF_ENABLES, 8'h02);
      cycles(2); check(irq_o, 1'b1);
      wr(period_timer_pkg::OFF_FLAGS, 8'h00);
      cycles(2); check(irq_o, 1'b0);
      rd(period_timer_pkg::OFF_FLAGS, d); check(d & 8'h02, 8'h00);
      done("flag");

      // reset in mid-run with the timer going
      wr(period_timer_pkg::OFF_PERIOD, 8'h55);
      wr(period_timer_pkg::OFF_CONTROL, ctl(4'h3, 1'b1, 2'b00));
      cycles(30);
      do_reset();
      rd(period_timer_pkg::OFF_COUNT, d);   check(d, 8'h00);
      rd(period_timer_pkg::OFF_PERIOD, d);  check(d, 8'hFF);
      rd(period_timer_pkg::OFF_CONTROL, d); check(d, 8'h00);
      cycles(40);
      rd(period_timer_pkg::OFF_COUNT, d);   check(d, 8'h00);
      done("second reset");
      results();
   end

endmodule // tb
